// ==== design/ld_route_pkg.sv ====
// Constants for the logical device decode and IRQ/DMA routing block.
// Assumes one 125 MHz clock and single-cycle host I/O strobes.
package ld_route_pkg;

  // ****************************************
  // Configuration register indices
  // ****************************************
  localparam logic [7:0] IDX_SOFT_RESET = 8'h02;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_POWER = 8'h22;
  localparam logic [7:0] IDX_CFG_BASE_LOW = 8'h26;
  localparam logic [7:0] IDX_CFG_BASE_HIGH = 8'h27;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_INTERRUPT_LINE_SELECT = 8'h70;
  localparam logic [7:0] IDX_DMA_CHANNEL_SELECT = 8'h74;
  localparam logic [7:0] IDX_DMA_SECOND_SELECT = 8'h75;
  localparam int SOFT_RESET_BIT = 0;
  localparam int ACTIVATE_BIT = 0;

  // ****************************************
  // Logical devices, one slot each
  // ****************************************
  localparam int NUM_SLOTS = 8;
  localparam logic [7:0][7:0] LD_NUMBERS = {8'h0E, 8'h0D, 8'h0C, 8'h0B, 8'h05, 8'h04, 8'h03, 8'h00};
  localparam logic [2:0] SLOT_FLOPPY = 3'h0;
  localparam logic [2:0] SLOT_PARALLEL = 3'h1;
  localparam logic [2:0] SLOT_UART2 = 3'h3;
  localparam int FIRST_UART_SLOT = 2;
  localparam int NUM_UARTS = 6;

  // ****************************************
  // Base address ranges and decode
  // ****************************************
  localparam logic [11:0] BASE_MIN = 12'h100;
  localparam logic [11:0] BASE_MAX_8 = 12'hFF8;
  localparam logic [11:0] BASE_MAX_4 = 12'hFFC;
  localparam logic [11:0] CFG_BASE_MAX = 12'hFFE;
  localparam logic [11:0] CFG_BASE_STRAP_LOW = 12'h02E;
  localparam logic [11:0] CFG_BASE_STRAP_HIGH = 12'h04E;
  localparam logic [11:0] BASE_RESET = 12'h000;

  // ****************************************
  // Serial port window offsets
  // ****************************************
  localparam logic [2:0] UART_DATA_DIVLO_OFF = 3'h0;
  localparam logic [2:0] UART_IER_DIVHI_OFF = 3'h1;
  localparam logic [2:0] UART_IDENT_FIFO_CTRL_OFF = 3'h2;
  localparam logic [2:0] UART_LINE_CONTROL_OFF = 3'h3;
  localparam logic [2:0] UART_LINE_STATUS_OFF = 3'h5;
  localparam logic [2:0] UART_SCRATCH_OFF = 3'h7;

  // ****************************************
  // Routing fields and reset values
  // ****************************************
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [3:0] IRQ_SEL_RESET = 4'h0;
  localparam logic [3:0] IRQ_SEL_RESET_FLOPPY = 4'h6;
  localparam logic [2:0] DMA_SEL_RESET = 3'h4;
  localparam logic [2:0] DMA_SEL_RESET_FLOPPY = 3'h2;
  localparam logic [2:0] DMA_FIRST = 3'h1;
  localparam logic [2:0] DMA_LAST = 3'h3;
  localparam int NUM_DMA_SRC = 3;
  localparam logic [2:0] ECP_MODE_FIFO = 3'b010;
  localparam logic [2:0] ECP_MODE_ECP = 3'b011;
  localparam logic [2:0] ECP_MODE_TEST = 3'b110;

  typedef enum logic [1:0] {
    BOOT_WAIT0 = 2'b00,
    BOOT_WAIT1 = 2'b01,
    BOOT_LOAD = 2'b11,
    BOOT_RUN = 2'b10
  } boot_t;

endpackage

// ==== design/irq_line_router.sv ====
// Routes each slot's gated interrupt onto one of fifteen host lines.
// Assumes gates and requests come from logic on the same clock.
module irq_line_router (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] gate,
  input wire logic [7:0] req,
  input wire logic [7:0][3:0] sel,
  output logic [15:1] irq_line
);

  typedef struct packed {
    logic [15:1] line;
  } irq_state_t;

  irq_state_t s_q;
  irq_state_t s_d;

  // ****************************************
  // Selection decode
  // ****************************************
  always_comb
  begin
    s_d = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (sel[i] != ld_route_pkg::IRQ_NONE && gate[i] && req[i])
      begin
        s_d.line[sel[i]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign irq_line = s_q.line;

endmodule

// ==== design/dma_channel_router.sv ====
// Routes the gated transfer requests onto DMA channels 1 to 3.
// Assumes gates and requests come from logic on the same clock.
module dma_channel_router (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] gate,
  input wire logic [2:0] req,
  input wire logic [2:0][2:0] sel,
  output logic [3:1] dma_req
);

  typedef struct packed {
    logic [3:1] chan;
  } dma_state_t;

  dma_state_t s_q;
  dma_state_t s_d;

  // ****************************************
  // Channel decode
  // ****************************************
  always_comb
  begin
    s_d = '0;
    for (int i = 0; i < ld_route_pkg::NUM_DMA_SRC; i++)
    begin
      if (sel[i] >= ld_route_pkg::DMA_FIRST && sel[i] <= ld_route_pkg::DMA_LAST && gate[i] && req[i])
      begin
        s_d.chan[sel[i][1:0]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dma_req = s_q.chan;

endmodule

// ==== design/ld_route_top.sv ====
// Configuration registers, base decode and IRQ/DMA routing of the
// logical devices. Assumes io_wr and io_rd are one-cycle strobes from
// the host bus controller on clk; function enables arrive on clk too.

// Notes on behaviour
// - Extra serial ports take bases 0x0100..0x0FF8 on eight-byte boundaries.
// - Serial window: data 0, enable 1, ident 2, line 3, status 5, scratch 7.
// - Index port at configuration base, data at base+1, moved by 0x26/0x27.
// - Strap low puts configuration port at 0x02E, high at 0x04E.
// - Match address bits 11..0; claim only when bits 15..12 are zero.
// - Index 0x70 low nibble picks IRQ line; zero picks none.
// - Interrupt selection resets to 0x00, floppy to 0x06.
// - Routed interrupts are active high; management interrupt is active low.
// - Interrupt needs nonzero selection plus the function's own enable bits.
// - Serial interrupt needs an enable bit 0..3 and aux output two set.
// - IRQ lines nobody selects and enables stay low.
// - All IRQ numbers 1 to 15 can be routed.
// - Index 0x74 bits 2..0: codes 1..3 pick channel, others none.
// - DMA selection resets to 0x02 floppy, 0x04 others; floppy selection is writable like the others.
// - DMA active only with selection 1..3 and function enable.
// - DMA channels nobody selects and enables stay idle.
// - Function disable, inactive device or bad base kills routed outputs.
// - Floppy routing off when transfer gate clear or powered down.
// - Standard and EPP parallel interrupt off while printer gate clear.
// - ECP: DMA follows transfer gate; IRQ follows service mask clear for 010, 011, 110.
// - Second serial port DMA follows its own DMA enable.
// - Activate and power bits are one bit; either write sets both.
// - Device with an out-of-range base is never claimed.
// - Index 0x75 ignores writes and reads zero.
module ld_route_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic config_address_strap,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic cfg_claim,
  output logic [7:0] dev_select,
  output logic [2:0] dev_offset,
  output logic [7:0] uart_reg_sel,
  input wire logic [7:0] irq_source,
  input wire logic [2:0] dma_source,
  input wire logic floppy_transfer_gate,
  input wire logic floppy_powered_down,
  input wire logic printer_irq_gate,
  input wire logic [2:0] parallel_mode,
  input wire logic ecp_service_mask,
  input wire logic ecp_transfer_gate,
  input wire logic [5:0][3:0] uart_interrupt_enable,
  input wire logic [5:0] uart_aux_output_two,
  input wire logic uart2_transfer_gate,
  input wire logic mgmt_source,
  input wire logic mgmt_enable,
  output logic [15:1] irq_line,
  output logic mgmt_interrupt_n,
  output logic [3:1] dma_req
);

  typedef struct packed {
    logic strap_meta;
    logic strap_sync;
    ld_route_pkg::boot_t boot;
    logic [7:0] index;
    logic [7:0] ldn;
    logic [11:0] cfg_base;
    logic [7:0] act;
    logic [7:0][11:0] base;
    logic [7:0][3:0] irq_sel;
    logic [7:0][2:0] dma_sel;
    logic [7:0] rdata;
    logic rvalid;
    logic mgmt;
  } state_t;

  // ****************************************
  // Functions
  // ****************************************
  function automatic state_t reset_state();
    state_t r;
    r = '0;
    r.boot = ld_route_pkg::BOOT_WAIT0;
    r.cfg_base = ld_route_pkg::CFG_BASE_STRAP_LOW;
    for (int i = 0; i < ld_route_pkg::NUM_SLOTS; i++)
    begin
      r.base[i] = ld_route_pkg::BASE_RESET;
      r.irq_sel[i] = ld_route_pkg::IRQ_SEL_RESET;
      r.dma_sel[i] = ld_route_pkg::DMA_SEL_RESET;
    end
    r.irq_sel[ld_route_pkg::SLOT_FLOPPY] = ld_route_pkg::IRQ_SEL_RESET_FLOPPY;
    r.dma_sel[ld_route_pkg::SLOT_FLOPPY] = ld_route_pkg::DMA_SEL_RESET_FLOPPY;
    return r;
  endfunction

  localparam state_t ST_RST = reset_state();

  // Returns {hit, slot} for a logical device number
  function automatic logic [3:0] slot_of(input logic [7:0] ldn);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < ld_route_pkg::NUM_SLOTS; i++)
    begin
      if (ld_route_pkg::LD_NUMBERS[i] == ldn)
      begin
        r = {1'b1, i[2:0]};
      end
    end
    return r;
  endfunction

  // Parallel port may sit on four-byte boundaries, all others on eight
  function automatic logic base_ok(input int slot, input logic [11:0] b);
    logic ok;
    ok = 1'b0;
    if (slot == int'(ld_route_pkg::SLOT_PARALLEL))
    begin
      ok = b >= ld_route_pkg::BASE_MIN && b <= ld_route_pkg::BASE_MAX_4 && b[1:0] == 2'h0;
    end
    else
    begin
      ok = b >= ld_route_pkg::BASE_MIN && b <= ld_route_pkg::BASE_MAX_8 && b[2:0] == 3'h0;
    end
    return ok;
  endfunction

  // Address window match for one slot
  function automatic logic base_hit(input int slot, input logic [11:0] b, input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    if (slot == int'(ld_route_pkg::SLOT_PARALLEL) && b[2])
    begin
      hit = a[11:2] == b[11:2];
    end
    else
    begin
      hit = a[11:3] == b[11:3];
    end
    return hit && a[15:12] == 4'h0;
  endfunction

  // ****************************************
  // Reset release and state
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  state_t s_q;
  state_t s_d;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************
  // Host decode
  // ****************************************
  logic [3:0] cur;
  logic cur_hit;
  logic [2:0] cur_slot;
  logic idx_hit;
  logic data_hit;
  logic [7:0][0:0] valid_base;
  logic [7:0] gate_irq;
  logic [2:0] gate_dma;
  logic ecp_forced;

  assign cur = slot_of(s_q.ldn);
  assign cur_hit = cur[3];
  assign cur_slot = cur[2:0];
  assign idx_hit = io_addr[15:12] == 4'h0 && io_addr[11:0] == s_q.cfg_base;
  assign data_hit = io_addr[15:12] == 4'h0 && io_addr[11:0] == s_q.cfg_base + 12'h001;
  assign cfg_claim = idx_hit || data_hit;
  assign dev_offset = io_addr[2:0];

  always_comb
  begin
    for (int i = 0; i < ld_route_pkg::NUM_SLOTS; i++)
    begin
      valid_base[i] = base_ok(i, s_q.base[i]);
      dev_select[i] = s_q.act[i] && valid_base[i][0] && base_hit(i, s_q.base[i], io_addr);
    end
  end

  // One-hot register strobe for whichever serial port is addressed
  always_comb
  begin
    uart_reg_sel = 8'h00;
    if (|dev_select[7:ld_route_pkg::FIRST_UART_SLOT])
    begin
      case (io_addr[2:0])
        ld_route_pkg::UART_DATA_DIVLO_OFF,
        ld_route_pkg::UART_IER_DIVHI_OFF,
        ld_route_pkg::UART_IDENT_FIFO_CTRL_OFF,
        ld_route_pkg::UART_LINE_CONTROL_OFF,
        ld_route_pkg::UART_LINE_STATUS_OFF,
        ld_route_pkg::UART_SCRATCH_OFF: uart_reg_sel[io_addr[2:0]] = 1'b1;
        default: uart_reg_sel[io_addr[2:0]] = 1'b1;
      endcase
    end
  end

  // ****************************************
  // Function gating
  // ****************************************
  assign ecp_forced = parallel_mode == ld_route_pkg::ECP_MODE_FIFO || parallel_mode == ld_route_pkg::ECP_MODE_ECP
                      || parallel_mode == ld_route_pkg::ECP_MODE_TEST;

  always_comb
  begin
    for (int i = 0; i < ld_route_pkg::NUM_SLOTS; i++)
    begin
      gate_irq[i] = 1'b0;
      if (i >= ld_route_pkg::FIRST_UART_SLOT)
      begin
        gate_irq[i] = |uart_interrupt_enable[i - ld_route_pkg::FIRST_UART_SLOT]
                      && uart_aux_output_two[i - ld_route_pkg::FIRST_UART_SLOT];
      end
    end
    gate_irq[ld_route_pkg::SLOT_FLOPPY] = floppy_transfer_gate && !floppy_powered_down;
    gate_irq[ld_route_pkg::SLOT_PARALLEL] = ecp_forced ? !ecp_service_mask : printer_irq_gate;
    gate_irq = gate_irq & s_q.act & valid_base;
    gate_dma[0] = floppy_transfer_gate && !floppy_powered_down;
    gate_dma[1] = ecp_transfer_gate;
    gate_dma[2] = uart2_transfer_gate;
    gate_dma = gate_dma & {s_q.act[ld_route_pkg::SLOT_UART2] && valid_base[ld_route_pkg::SLOT_UART2][0],
                           s_q.act[ld_route_pkg::SLOT_PARALLEL] && valid_base[ld_route_pkg::SLOT_PARALLEL][0],
                           s_q.act[ld_route_pkg::SLOT_FLOPPY] && valid_base[ld_route_pkg::SLOT_FLOPPY][0]};
  end

  // ****************************************
  // Register next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.strap_meta = config_address_strap;
    s_d.strap_sync = s_q.strap_meta;
    s_d.rvalid = 1'b0;
    s_d.mgmt = mgmt_source && mgmt_enable;
    case (s_q.boot)
      ld_route_pkg::BOOT_WAIT0: s_d.boot = ld_route_pkg::BOOT_WAIT1;
      ld_route_pkg::BOOT_WAIT1: s_d.boot = ld_route_pkg::BOOT_LOAD;
      ld_route_pkg::BOOT_LOAD:
      begin
        s_d.boot = ld_route_pkg::BOOT_RUN;
        s_d.cfg_base = s_q.strap_sync ? ld_route_pkg::CFG_BASE_STRAP_HIGH
                                      : ld_route_pkg::CFG_BASE_STRAP_LOW;
      end
      ld_route_pkg::BOOT_RUN: s_d.boot = ld_route_pkg::BOOT_RUN;
      default: s_d.boot = ld_route_pkg::BOOT_WAIT0;
    endcase
    if (io_wr && idx_hit)
    begin
      s_d.index = io_wdata;
    end
    if (io_wr && data_hit)
    begin
      case (s_q.index)
        ld_route_pkg::IDX_SOFT_RESET:
        begin
          if (io_wdata[ld_route_pkg::SOFT_RESET_BIT])
          begin
            s_d.act = ST_RST.act;
            s_d.irq_sel = ST_RST.irq_sel;
            s_d.dma_sel = ST_RST.dma_sel;
          end
        end
        ld_route_pkg::IDX_LDN: s_d.ldn = io_wdata;
        ld_route_pkg::IDX_POWER: s_d.act = io_wdata;
        ld_route_pkg::IDX_CFG_BASE_LOW: s_d.cfg_base[7:0] = {io_wdata[7:1], 1'b0};
        ld_route_pkg::IDX_CFG_BASE_HIGH: s_d.cfg_base[11:8] = io_wdata[3:0];
        default: s_d.index = s_d.index;
      endcase
      if (cur_hit)
      begin
        case (s_q.index)
          ld_route_pkg::IDX_ACTIVATE: s_d.act[cur_slot] = io_wdata[ld_route_pkg::ACTIVATE_BIT];
          ld_route_pkg::IDX_BASE_HIGH: s_d.base[cur_slot][11:8] = io_wdata[3:0];
          ld_route_pkg::IDX_BASE_LOW: s_d.base[cur_slot][7:0] = io_wdata;
          ld_route_pkg::IDX_INTERRUPT_LINE_SELECT: s_d.irq_sel[cur_slot] = io_wdata[3:0];
          ld_route_pkg::IDX_DMA_CHANNEL_SELECT: s_d.dma_sel[cur_slot] = io_wdata[2:0];
          default: s_d.index = s_d.index;
        endcase
      end
    end
    if (io_rd && cfg_claim)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 8'h00;
      if (idx_hit)
      begin
        s_d.rdata = s_q.index;
      end
      else
      begin
        case (s_q.index)
          ld_route_pkg::IDX_LDN: s_d.rdata = s_q.ldn;
          ld_route_pkg::IDX_POWER: s_d.rdata = s_q.act;
          ld_route_pkg::IDX_CFG_BASE_LOW: s_d.rdata = s_q.cfg_base[7:0];
          ld_route_pkg::IDX_CFG_BASE_HIGH: s_d.rdata = {4'h0, s_q.cfg_base[11:8]};
          ld_route_pkg::IDX_ACTIVATE: s_d.rdata = {7'h00, cur_hit && s_q.act[cur_slot]};
          ld_route_pkg::IDX_BASE_HIGH: s_d.rdata = cur_hit ? {4'h0, s_q.base[cur_slot][11:8]} : 8'h00;
          ld_route_pkg::IDX_BASE_LOW: s_d.rdata = cur_hit ? s_q.base[cur_slot][7:0] : 8'h00;
          ld_route_pkg::IDX_INTERRUPT_LINE_SELECT: s_d.rdata = cur_hit ? {4'h0, s_q.irq_sel[cur_slot]} : 8'h00;
          ld_route_pkg::IDX_DMA_CHANNEL_SELECT: s_d.rdata = cur_hit ? {5'h00, s_q.dma_sel[cur_slot]} : 8'h00;
          default: s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= ST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Routing
  // ****************************************
  irq_line_router u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .gate(gate_irq),
    .req(irq_source),
    .sel(s_q.irq_sel),
    .irq_line(irq_line)
  );

  dma_channel_router u_dma (
    .clk(clk),
    .rst_n(rst_n),
    .gate(gate_dma),
    .req(dma_source),
    .sel({s_q.dma_sel[ld_route_pkg::SLOT_UART2], s_q.dma_sel[ld_route_pkg::SLOT_PARALLEL],
          s_q.dma_sel[ld_route_pkg::SLOT_FLOPPY]}),
    .dma_req(dma_req)
  );

  assign mgmt_interrupt_n = !s_q.mgmt;
  assign io_rdata = s_q.rdata;
  assign io_rvalid = s_q.rvalid;

endmodule

// ==== verification/ld_route_checker.sv ====
// Concurrent checks on the ports of the routing block top.
// Assumes it is bound into ld_route_top; one clock domain.
module ld_route_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_rvalid,
  input wire logic cfg_claim,
  input wire logic [7:0] dev_select,
  input wire logic [2:0] dev_offset,
  input wire logic [7:0] uart_reg_sel,
  input wire logic [7:0] irq_source,
  input wire logic [2:0] dma_source,
  input wire logic ecp_transfer_gate,
  input wire logic uart2_transfer_gate,
  input wire logic mgmt_source,
  input wire logic mgmt_enable,
  input wire logic [15:1] irq_line,
  input wire logic mgmt_interrupt_n,
  input wire logic [3:1] dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  logic live;
  // Counts edges since reset release; checks wait for the internal sync
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  assign live = (up_q > 3'h4);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****************************************
  // Assertions
  // ****************************************
  sequence s_cfg_read;
    live && io_rd && cfg_claim;
  endsequence
  AST_READ_ANSWER: assert property (s_cfg_read |=> io_rvalid)
    else $error("config read not answered");
  AST_RVALID_CAUSE: assert property (io_rvalid |-> $past(io_rd && cfg_claim))
    else $error("read valid without claimed read");
  AST_HIGH_ADDR: assert property (io_addr[15:12] != 4'h0 |-> !cfg_claim && dev_select == 8'h00)
    else $error("cycle claimed with high address bits set");
  AST_UART_WINDOW: assert property (dev_select[7:2] != 6'h00 |->
    uart_reg_sel == (8'h01 << io_addr[2:0]) && dev_offset == io_addr[2:0])
    else $error("serial register select wrong");
  AST_MGMT_LOW: assert property (live |-> mgmt_interrupt_n == !$past(mgmt_source && mgmt_enable))
    else $error("management interrupt level wrong");
  AST_IRQ_IDLE: assert property (live && $past(irq_source) == 8'h00 |-> irq_line == 15'h0000)
    else $error("irq line driven with no source");
  AST_DMA_IDLE: assert property (live && $past(dma_source) == 3'h0 |-> dma_req == 3'h0)
    else $error("dma request with no source");
  AST_PAR_DMA: assert property (live && $past(dma_source == 3'h2 && !ecp_transfer_gate) |-> dma_req == 3'h0)
    else $error("parallel dma passed a closed gate");
  AST_UART2_DMA: assert property (live && $past(dma_source == 3'h4 && !uart2_transfer_gate) |-> dma_req == 3'h0)
    else $error("serial dma passed a closed gate");
endmodule

// ==== verification/host_bus_model.sv ====
// Host bus controller: one-cycle config strobes on the block's port.
// Assumes read data arrives exactly one cycle after the read strobe.
module host_bus_model (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wr <= 1'b1;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    // Released data lines do not keep the old value
    io_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(posedge clk);
    d = io_rdata;
    ok = io_rvalid;
  endtask
  task automatic probe(input logic [15:0] a);
    @(posedge clk);
    io_addr <= a;
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the logical device decode and routing block.
// Assumes host_bus_model drives the config port; checker bound below.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, strap, io_wr, io_rd, io_rvalid, cfg_claim, fg, pd, pig, esm, etg, u2g, ms, me, mgmt_n, ok;
  logic [15:0] io_addr, ei;
  logic [7:0] io_wdata, io_rdata, dev_select, uart_reg_sel, irq_source, act, g;
  logic [2:0] dev_offset, dma_source, pm, dg;
  logic [3:0] ed;
  logic [5:0][3:0] uie;
  logic [5:0] aux;
  logic [15:1] irq_line;
  logic [3:1] dma_req;
  logic [11:0] cfg_base;
  logic [11:0] base [8];
  int isel [8];
  int dsel [8];
  int bad_count, n_tests, cyc, seed, r, r2, s;
  ld_route_top dut_u (.clk(clk), .arst_n(arst_n), .config_address_strap(strap), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .cfg_claim(cfg_claim), .dev_select(dev_select), .dev_offset(dev_offset), .uart_reg_sel(uart_reg_sel),
    .irq_source(irq_source), .dma_source(dma_source), .floppy_transfer_gate(fg), .floppy_powered_down(pd),
    .printer_irq_gate(pig), .parallel_mode(pm), .ecp_service_mask(esm), .ecp_transfer_gate(etg),
    .uart_interrupt_enable(uie), .uart_aux_output_two(aux), .uart2_transfer_gate(u2g), .mgmt_source(ms),
    .mgmt_enable(me), .irq_line(irq_line), .mgmt_interrupt_n(mgmt_n), .dma_req(dma_req));
  host_bus_model host_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic c, input string m);
    n_tests++;
    if (!c)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic reset(input logic st);
    @(posedge clk);
    strap <= st;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    cfg_base = st ? 12'h04E : 12'h02E;
  endtask
  // Index write then data write; the model follows relocation
  task automatic cw(input logic [7:0] idx, input logic [7:0] d);
    host_u.wr({4'h0, cfg_base}, idx);
    host_u.wr({4'h0, cfg_base} + 16'h0001, d);
    if (idx == 8'h26)
      cfg_base = {cfg_base[11:8], d[7:1], 1'b0};
    if (idx == 8'h27)
      cfg_base = {d[3:0], cfg_base[7:0]};
  endtask
  task automatic cr(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    host_u.wr({4'h0, cfg_base}, idx);
    host_u.rd({4'h0, cfg_base} + 16'h0001, d, ok);
    chk(ok === 1'b1 && d === e, "config read");
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {strap, irq_source, dma_source, fg, pd, pig, pm, esm, etg, uie, aux, u2g, ms, me} = '0;
    arst_n = 1'b0;
    {bad_count, n_tests, cyc} = '0;
    seed = 34124;
    reset(1'b1);
    host_u.probe(16'h004F);
    @(negedge clk);
    chk(cfg_claim === 1'b1, "strap high port");
    cw(8'h26, 8'h71);
    cw(8'h27, 8'h03);
    cw(ld_route_pkg::IDX_LDN, 8'h05);
    cr(ld_route_pkg::IDX_LDN, 8'h05);
    host_u.probe(16'h1370);
    @(negedge clk);
    chk(cfg_claim === 1'b0, "high address claimed");
    reset(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      cw(ld_route_pkg::IDX_LDN, ld_route_pkg::LD_NUMBERS[i]);
      cr(8'h70, (i == 0) ? 8'h06 : 8'h00);
      cr(8'h74, (i == 0) ? 8'h02 : 8'h04);
      cw(8'h75, 8'hFF);
      cr(8'h75, 8'h00);
      base[i] = (i == 4) ? 12'h0F8 : (i == 7) ? 12'hFF8 : 12'h100 + 12'(8 * (60 * i + (r & 63) % 60));
      isel[i] = (r >>> 8) & 15;
      dsel[i] = (i == 0) ? 2 : (r >>> 12) & 7;
      cw(8'h60, {4'h0, base[i][11:8]});
      cw(8'h61, base[i][7:0]);
      cw(8'h70, 8'(isel[i]));
      cw(8'h74, 8'(dsel[i]));
    end
    act = 8'($random(seed)) | 8'h81;
    cw(8'h22, act);
    for (int i = 0; i < 8; i++)
    begin
      cw(ld_route_pkg::IDX_LDN, ld_route_pkg::LD_NUMBERS[i]);
      cr(8'h30, {7'h00, act[i]});
      for (int o = 0; o < 8; o++)
      begin
        host_u.probe({4'h0, base[i]} + 16'(o));
        @(negedge clk);
        chk(dev_select === ((act[i] && i != 4) ? 8'h01 << i : 8'h00), "decode");
        chk(uart_reg_sel === ((act[i] && i > 1 && i != 4) ? 8'h01 << o : 8'h00), "serial window");
      end
    end
    for (int it = 0; it < 320; it++)
    begin
      if (it % 20 == 0)
      begin
        @(posedge clk);
        me <= 1'b0;
        s = (it / 20) % 8;
        isel[s] = (it / 20) % 16;
        cw(ld_route_pkg::IDX_LDN, ld_route_pkg::LD_NUMBERS[s]);
        cw(8'h70, 8'(isel[s]));
        if (s != 0)
        begin
          dsel[s] = (it / 20) % 8;
          cw(8'h74, 8'(dsel[s]));
        end
      end
      r = $random(seed);
      r2 = $random(seed);
      @(posedge clk);
      irq_source <= (it % 2) ? 8'h01 << r[2:0] : r[7:0];
      dma_source <= (it % 2) ? 3'h1 << (r[4:3] % 2'h3) : r[10:8];
      {fg, pd, pig, esm, etg, u2g, ms} <= r[17:11];
      pm <= r[20:18];
      uie <= 24'(r2);
      aux <= (it % 4 == 0) ? 6'h00 : r2[29:24];
      me <= r[21] && !(2 inside {isel});
      @(posedge clk);
      @(negedge clk);
      g[0] = fg && !pd;
      g[1] = (pm == 3'b010 || pm == 3'b011 || pm == 3'b110) ? !esm : pig;
      for (int k = 2; k < 8; k++)
        g[k] = uie[k - 2] != 4'h0 && aux[k - 2];
      ei = '0;
      ed = '0;
      dg = {u2g, etg, g[0]};
      for (int k = 0; k < 8; k++)
        if (act[k] && k != 4 && isel[k] != 0 && g[k] && irq_source[k])
          ei[isel[k]] = 1'b1;
      for (int j = 0; j < 3; j++)
      begin
        s = (j == 2) ? 3 : j;
        if (act[s] && dsel[s] >= 1 && dsel[s] <= 3 && dg[j] && dma_source[j])
          ed[dsel[s]] = 1'b1;
      end
      chk(irq_line === ei[15:1], "irq routing");
      chk(dma_req === ed[3:1], "dma routing");
      chk(mgmt_n === !(ms && me), "management interrupt");
    end
    // Soft reset clears activation of all devices; the selections of the selected device 0x0E read back at reset values
    cw(8'h02, 8'h01);
    cr(8'h22, 8'h00);
    cr(8'h70, 8'h00);
    cr(8'h74, 8'h04);
    results();
  end
endmodule
bind ld_route_top ld_route_checker chk_u (.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_rd(io_rd),
  .io_rvalid(io_rvalid), .cfg_claim(cfg_claim), .dev_select(dev_select), .dev_offset(dev_offset),
  .uart_reg_sel(uart_reg_sel), .irq_source(irq_source), .dma_source(dma_source),
  .ecp_transfer_gate(ecp_transfer_gate), .uart2_transfer_gate(uart2_transfer_gate),
  .mgmt_source(mgmt_source), .mgmt_enable(mgmt_enable), .irq_line(irq_line),
  .mgmt_interrupt_n(mgmt_interrupt_n), .dma_req(dma_req));
